// file: include/rtcc_pkg.sv
// constants and types shared by the rtc control and status block
package rtcc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_TIME_LAST    = 8'h06;
  localparam logic [7:0] ADDR_STATUS       = 8'h07;
  localparam logic [7:0] ADDR_INT_CTRL     = 8'h08;
  localparam logic [7:0] ADDR_ANALOG_TRIM  = 8'h0a;
  localparam logic [7:0] ADDR_DIGITAL_TRIM = 8'h0b;

  // status_flags bit positions
  localparam int SR_POWER_FAIL = 0;
  localparam int SR_BATTERY    = 1;
  localparam int SR_ALARM      = 2;
  localparam int SR_TIME_WEN   = 4;
  localparam int SR_OSC_DIS    = 6;
  localparam int SR_CLR_ON_RD  = 7;

  // interrupt_control bit positions
  localparam int INT_FREQ_LSB  = 0;
  localparam int INT_FREQ_W    = 4;
  localparam int INT_BAT_DIS   = 4;
  localparam int INT_LOW_POWER = 5;
  localparam int INT_ALARM_EN  = 6;
  localparam int INT_PULSE     = 7;

  // trim fields
  localparam int ATRIM_W       = 6;
  localparam int ATRIM_BAT_LSB = 6;
  localparam int DTRIM_W       = 3;

  // values after reset; power fail reads set after a cold start
  localparam logic              POWER_FAIL_RST = 1'b1;
  localparam logic [7:0]        INT_CTRL_RST   = 8'h00;
  localparam logic [7:0]        ATRIM_RST      = 8'h00;
  localparam logic [DTRIM_W-1:0] DTRIM_RST     = 3'h0;

  // timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int ALARM_PULSE_MS  = 250;
  localparam int ALARM_PULSE_CYC =
    ALARM_PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int OSC_HZ          = 32768;

  // frequency output taps into the divider chain
  localparam logic [3:0] FREQ_OFF    = 4'h0;
  localparam logic [3:0] FREQ_32K    = 4'h1;
  localparam logic [3:0] FREQ_4K     = 4'h2;
  localparam logic [3:0] FREQ_1K     = 4'h3;
  localparam int         TAP_4K      = 2;
  localparam int         TAP_1K      = 4;
  localparam int         TAP_OFS     = 4;
  localparam int         SEC_CNT_W   = 5;

  // digital trim
  localparam int PPM_SCALE     = 1000000;
  localparam int TRIM_STEP_PPM = 20;
  localparam int TRIM_ACC_W    = 22;

  // load capacitance, in half picofarads
  localparam logic [6:0] CAP_BASE_HALF_PF = 7'h12;

  // one register access from the serial engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } rtcc_acc_s;

  // sec, min, hour, date, month, weekday bytes, index 0 = sec
  typedef logic [5:0][7:0] rtcc_byte6_t;
endpackage

// file: verilog/rtcc_sync2.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module rtcc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,    // block clock
  input  wire logic         clear_on_read_enable_n_in, // async reset, active low
  input  wire logic [W-1:0] d_in,      // asynchronous level
  output logic      [W-1:0] q_out      // synchronised level
);
  logic [W-1:0] meta;

  initial
  begin
    if (W < 1)
      $error("rtcc_sync2: width must be at least 1");
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// file: verilog/rtcc_alarm_field.sv
// compare of one alarm byte against one time byte
`timescale 1ns/1ns
module rtcc_alarm_field (
  input  wire logic [7:0] alarm_in,   // alarm byte, bit7 enables
  input  wire logic [7:0] time_in,    // current time byte
  output logic            enabled_out, // field takes part
  output logic            match_out    // field agrees or is ignored
);
  always_comb
  begin
    enabled_out = alarm_in[7];
    match_out   = !alarm_in[7] || (alarm_in[6:0] == time_in[6:0]);
  end
endmodule

// file: verilog/rtcc_ctrl.sv
// control and status logic of the battery backed real time clock
//
// How it works
// - power fail flag set after total loss
// - cold start defaults, time held until written
// - battery flag set on backup, write clears
// - alarm flag set on match, write clears
// - match during status read survives clear
// - time writes need write enable, reset zero
// - stop after time write starts, realigns tick
// - oscillator disable selects external pin clock
// - clear on read clears battery, alarm only
// - frequency code selects shared pin rate
// - nonzero frequency overrides and disables alarm
// - battery output disable silences pin on backup
// - low power switchover drops trip condition
// - alarm enable gates all alarm activity
// - pulse mode gives 250 ms low pulse
// - level mode holds pin until flag cleared
// - analog trim sets pin load capacitance
// - battery offset shifts capacitance on backup
// - digital trim sign plus 40/20 ppm weights
// - alarm field counts only when enabled
`timescale 1ns/1ns
module rtcc_ctrl #(
  parameter int OSC_PER_SEC        = rtcc_pkg::OSC_HZ,
  parameter int ALARM_PULSE_CYCLES = rtcc_pkg::ALARM_PULSE_CYC
) (
  input  wire logic                  clk_in,            // 25 MHz clock
  input  wire logic                  clear_on_read_enable_n_in,         // async reset, low
  input  wire rtcc_pkg::rtcc_acc_s   acc_in,            // register access
  input  wire logic                  bus_start_in,      // start seen, pulse
  input  wire logic                  bus_stop_in,       // valid stop, pulse
  input  wire rtcc_pkg::rtcc_byte6_t time_in,           // current time
  input  wire rtcc_pkg::rtcc_byte6_t alarm_in,          // alarm bytes
  input  wire logic                  xtal_osc_in,       // crystal oscillator
  input  wire logic                  crystal_in_pin_in, // external 32 kHz
  input  wire logic                  vdd_lt_bat_in,     // vdd < vbat - hys
  input  wire logic                  vdd_lt_trip_in,    // vdd < trip level
  output logic [7:0]                 reg_rdata_out,     // read data
  output logic                       time_wr_ok_out,    // time write taken
  output logic                       count_run_out,     // counters may run
  output logic                       sec_tick_out,      // one second pulse
  output logic                       xtal_enable_out,   // oscillator on
  output logic                       on_backup_out,     // running on battery
  output logic [6:0]                 load_cap_out,      // per pin, half pF
  output logic                       irq_fout_o_out,    // pin output value
  output logic                       irq_fout_oe_out    // pin pulled low
);
  import rtcc_pkg::*;

  localparam int PRE_W   = $clog2(OSC_PER_SEC) + 1;
  localparam int CHAIN_W = PRE_W - 1 + SEC_CNT_W;
  localparam int PULSE_W = $clog2(ALARM_PULSE_CYCLES + 1);
  localparam logic [TRIM_ACC_W-1:0] TRIM_UNIT =
    TRIM_ACC_W'(TRIM_STEP_PPM * OSC_PER_SEC);
  localparam logic [TRIM_ACC_W-1:0] TRIM_WRAP = TRIM_ACC_W'(PPM_SCALE);
  localparam logic [PRE_W-1:0] PRE_NOM  = PRE_W'(OSC_PER_SEC - 1);
  localparam logic [PRE_W-1:0] PRE_LONG = PRE_W'(OSC_PER_SEC);
  localparam logic [PRE_W-1:0] PRE_SHORT = PRE_W'(OSC_PER_SEC - 2);
  localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(ALARM_PULSE_CYCLES);

  initial
  begin
    if (OSC_PER_SEC < 4 || (OSC_PER_SEC & (OSC_PER_SEC - 1)) != 0)
      $error("rtcc_ctrl: OSC_PER_SEC must be a power of two, 4 or more");
    if (OSC_PER_SEC > 65536)
      $error("rtcc_ctrl: OSC_PER_SEC overflows the trim accumulator");
    if (ALARM_PULSE_CYCLES < 1)
      $error("rtcc_ctrl: ALARM_PULSE_CYCLES must be at least 1");
  end

  // register state
  logic                  power_fail_flag;
  logic                  battery_flag;
  logic                  alarm_flag;
  logic                  time_write_enable;
  logic                  oscillator_disable;
  logic                  clear_on_read_enable;
  logic [7:0]            interrupt_control;
  logic [7:0]            analog_trim;
  logic [DTRIM_W-1:0]    digital_trim;
  logic [7:0]            status_flags;

  // other state
  logic [1:0]            sup_sync;
  logic [1:0]            osc_sync;
  logic                  osc_prev;
  logic                  time_wr_pend;
  logic                  bat_clr_pend;
  logic                  alm_clr_pend;
  logic [PRE_W-1:0]      presc;
  logic [SEC_CNT_W-1:0]  sec_cnt;
  logic [TRIM_ACC_W-1:0] trim_acc;
  logic                  trim_adj;
  logic                  eval_pend;
  logic                  match_prev;
  logic [PULSE_W-1:0]    pulse_cnt;

  // combinational terms
  logic                  osc_src;
  logic                  osc_rise;
  logic                  on_backup_now;
  logic                  bat_set;
  logic                  alarm_event;
  logic                  alarm_active;
  logic                  wr_status;
  logic                  rd_status;
  logic                  stop_commit;
  logic [PRE_W-1:0]      pre_limit;
  logic                  sec_wrap;
  logic [TRIM_ACC_W-1:0] next_trim_sum;
  logic [CHAIN_W-1:0]    div_chain;
  logic [3:0]            freq_select;
  logic                  fout_level;
  logic                  pin_low_req;
  logic [5:0]            field_en;
  logic [5:0]            field_match;
  logic                  match_now;
  logic [6:0]            cap_main;
  logic [6:0]            next_load_cap;

  rtcc_sync2 #(
    .W(2)
  ) u_sup_sync (
    .clk_in   (clk_in),
    .clear_on_read_enable_n_in(clear_on_read_enable_n_in),
    .d_in     ({vdd_lt_trip_in, vdd_lt_bat_in}),
    .q_out    (sup_sync)
  );

  rtcc_sync2 #(
    .W(2)
  ) u_osc_sync (
    .clk_in   (clk_in),
    .clear_on_read_enable_n_in(clear_on_read_enable_n_in),
    .d_in     ({crystal_in_pin_in, xtal_osc_in}),
    .q_out    (osc_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_field
      rtcc_alarm_field u_field (
        .alarm_in   (alarm_in[gi]),
        .time_in    (time_in[gi]),
        .enabled_out(field_en[gi]),
        .match_out  (field_match[gi])
      );
    end
  endgenerate

  always_comb
  begin
    freq_select   = interrupt_control[INT_FREQ_LSB +: INT_FREQ_W];
    osc_src       = oscillator_disable ? osc_sync[1] : osc_sync[0];
    osc_rise      = osc_src && !osc_prev;
    on_backup_now = sup_sync[0] &&
      (interrupt_control[INT_LOW_POWER] || sup_sync[1]);
    bat_set       = on_backup_now && !on_backup_out;
    alarm_active  = interrupt_control[INT_ALARM_EN] &&
      (freq_select == FREQ_OFF);
    match_now     = (|field_en) && (&field_match);
    alarm_event   = eval_pend && alarm_active && match_now &&
      !match_prev;
    wr_status     = acc_in.wr && (acc_in.addr == ADDR_STATUS);
    rd_status     = acc_in.rd && (acc_in.addr == ADDR_STATUS);
    time_wr_ok_out = acc_in.wr && (acc_in.addr <= ADDR_TIME_LAST) &&
      time_write_enable;
    stop_commit   = bus_stop_in && time_wr_pend;
    status_flags  = '0;
    status_flags[SR_POWER_FAIL] = power_fail_flag;
    status_flags[SR_BATTERY]    = battery_flag;
    status_flags[SR_ALARM]      = alarm_flag;
    status_flags[SR_TIME_WEN]   = time_write_enable;
    status_flags[SR_OSC_DIS]    = oscillator_disable;
    status_flags[SR_CLR_ON_RD]  = clear_on_read_enable;
  end

  // prescaler limit with digital trim
  always_comb
  begin
    if (!trim_adj)
      pre_limit = PRE_NOM;
    else if (digital_trim[DTRIM_W-1])
      pre_limit = PRE_LONG;
    else
      pre_limit = PRE_SHORT;
    sec_wrap      = osc_rise && (presc >= pre_limit);
    next_trim_sum = trim_acc +
      TRIM_ACC_W'(TRIM_UNIT * digital_trim[1:0]);
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_src;
  end

  // one second prescaler, realigned by the stop of a time write
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      presc   <= '0;
      sec_cnt <= '0;
    end
    else if (stop_commit)
    begin
      presc   <= '0;
      sec_cnt <= '0;
    end
    else if (sec_wrap)
    begin
      presc   <= '0;
      sec_cnt <= sec_cnt + 1'b1;
    end
    else if (osc_rise)
      presc <= presc + 1'b1;
  end

  // fractional ppm accumulator, one correction count when it wraps
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      trim_acc <= '0;
      trim_adj <= 1'b0;
    end
    else if (sec_wrap)
    begin
      if (next_trim_sum >= TRIM_WRAP)
      begin
        trim_acc <= next_trim_sum - TRIM_WRAP;
        trim_adj <= 1'b1;
      end
      else
      begin
        trim_acc <= next_trim_sum;
        trim_adj <= 1'b0;
      end
    end
  end

  // counting starts only after a committed time write
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      count_run_out <= 1'b0;
      sec_tick_out  <= 1'b0;
      time_wr_pend  <= 1'b0;
    end
    else
    begin
      sec_tick_out <= sec_wrap && count_run_out;
      if (stop_commit)
        count_run_out <= 1'b1;
      if (time_wr_ok_out)
        time_wr_pend <= 1'b1;
      else if (bus_stop_in || bus_start_in)
        time_wr_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
      power_fail_flag <= POWER_FAIL_RST;
    else if (stop_commit)
      power_fail_flag <= 1'b0;
  end

  // control bits of status_flags
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      time_write_enable    <= 1'b0;
      oscillator_disable   <= 1'b0;
      clear_on_read_enable <= 1'b0;
    end
    else if (wr_status)
    begin
      time_write_enable    <= acc_in.data[SR_TIME_WEN];
      oscillator_disable   <= acc_in.data[SR_OSC_DIS];
      clear_on_read_enable <= acc_in.data[SR_CLR_ON_RD];
    end
  end

  // clear on read arms at the read, any new set disarms it
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      bat_clr_pend <= 1'b0;
      alm_clr_pend <= 1'b0;
    end
    else
    begin
      if (bat_set)
        bat_clr_pend <= 1'b0;
      else if (rd_status && clear_on_read_enable)
        bat_clr_pend <= 1'b1;
      else if (bus_stop_in || bus_start_in)
        bat_clr_pend <= 1'b0;
      if (alarm_event)
        alm_clr_pend <= 1'b0;
      else if (rd_status && clear_on_read_enable)
        alm_clr_pend <= 1'b1;
      else if (bus_stop_in || bus_start_in)
        alm_clr_pend <= 1'b0;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      battery_flag <= 1'b0;
      alarm_flag   <= 1'b0;
    end
    else
    begin
      if (bat_set)
        battery_flag <= 1'b1;
      else if ((wr_status && !acc_in.data[SR_BATTERY]) ||
               (bus_stop_in && bat_clr_pend))
        battery_flag <= 1'b0;
      if (alarm_event)
        alarm_flag <= 1'b1;
      else if ((wr_status && !acc_in.data[SR_ALARM]) ||
               (bus_stop_in && alm_clr_pend))
        alarm_flag <= 1'b0;
    end
  end

  // remaining control registers
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      interrupt_control <= INT_CTRL_RST;
      analog_trim       <= ATRIM_RST;
      digital_trim      <= DTRIM_RST;
    end
    else if (acc_in.wr)
    begin
      if (acc_in.addr == ADDR_INT_CTRL)
        interrupt_control <= acc_in.data;
      if (acc_in.addr == ADDR_ANALOG_TRIM)
        analog_trim <= acc_in.data;
      if (acc_in.addr == ADDR_DIGITAL_TRIM)
        digital_trim <= acc_in.data[DTRIM_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
      reg_rdata_out <= '0;
    else if (acc_in.rd)
    begin
      case (acc_in.addr)
        ADDR_STATUS:       reg_rdata_out <= status_flags;
        ADDR_INT_CTRL:     reg_rdata_out <= interrupt_control;
        ADDR_ANALOG_TRIM:  reg_rdata_out <= analog_trim;
        ADDR_DIGITAL_TRIM: reg_rdata_out <= {5'h00, digital_trim};
        default:           reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // alarm compare one cycle after the tick, once time has moved
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      eval_pend  <= 1'b0;
      match_prev <= 1'b0;
    end
    else
    begin
      eval_pend <= sec_tick_out;
      if (eval_pend)
        match_prev <= match_now && alarm_active;
    end
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
      pulse_cnt <= '0;
    else if (!alarm_active || !interrupt_control[INT_PULSE])
      pulse_cnt <= '0;
    else if (alarm_event)
      pulse_cnt <= PULSE_LEN;
    else if (pulse_cnt != '0)
      pulse_cnt <= pulse_cnt - 1'b1;
  end

  // shared pin: frequency output, else alarm
  always_comb
  begin
    div_chain = {sec_cnt, presc[PRE_W-2:0]};
    case (freq_select)
      FREQ_OFF: fout_level = 1'b1;
      FREQ_32K: fout_level = osc_src;
      FREQ_4K:  fout_level = div_chain[TAP_4K];
      FREQ_1K:  fout_level = div_chain[TAP_1K];
      default:
      begin
        if (32'(freq_select) + TAP_OFS < CHAIN_W)
          fout_level = div_chain[32'(freq_select) + TAP_OFS];
        else
          fout_level = div_chain[CHAIN_W-1];
      end
    endcase
    if (freq_select != FREQ_OFF)
      pin_low_req = !fout_level;
    else if (!alarm_active)
      pin_low_req = 1'b0;
    else if (interrupt_control[INT_PULSE])
      pin_low_req = (pulse_cnt != '0);
    else
      pin_low_req = alarm_flag;
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      on_backup_out   <= 1'b0;
      irq_fout_oe_out <= 1'b0;
    end
    else
    begin
      on_backup_out   <= on_backup_now;
      irq_fout_oe_out <= pin_low_req &&
        !(on_backup_out && interrupt_control[INT_BAT_DIS]);
    end
  end

  assign irq_fout_o_out = 1'b0;

  // load capacitance per pin in half picofarads
  always_comb
  begin
    cap_main = {1'b0, !analog_trim[ATRIM_W-1], analog_trim[ATRIM_W-2:0]}
      + CAP_BASE_HALF_PF;
    next_load_cap = cap_main;
    if (on_backup_out)
    begin
      case (analog_trim[ATRIM_BAT_LSB +: 2])
        2'h1:    next_load_cap = cap_main - 7'h01;
        2'h2:    next_load_cap = cap_main + 7'h01;
        2'h3:    next_load_cap = cap_main + 7'h02;
        default: next_load_cap = cap_main;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
    begin
      load_cap_out    <= '0;
      xtal_enable_out <= 1'b0;
    end
    else
    begin
      load_cap_out    <= next_load_cap;
      xtal_enable_out <= !oscillator_disable;
    end
  end
endmodule

// file: bench/rtcc_ctrl_monitor.sv
// port assertions of the rtc control block
`timescale 1ns/1ns
module rtcc_ctrl_monitor (
  input wire logic                clk_in,          // clock
  input wire logic                clear_on_read_enable_n_in,       // reset
  input wire rtcc_pkg::rtcc_acc_s acc_in,          // access
  input wire logic                bus_stop_in,     // stop
  input wire logic                vdd_lt_bat_in,   // main low
  input wire logic [7:0]          reg_rdata_out,   // read data
  input wire logic                time_wr_ok_out,  // time write
  input wire logic                count_run_out,   // running
  input wire logic                sec_tick_out,    // tick
  input wire logic                xtal_enable_out, // osc on
  input wire logic                on_backup_out,   // backup
  input wire logic [6:0]          load_cap_out     // load cap
);
  import rtcc_pkg::*;
  logic wen_seen;

  // write enable as last written by the host
  always_ff @(posedge clk_in or negedge clear_on_read_enable_n_in)
  begin
    if (!clear_on_read_enable_n_in)
      wen_seen <= 1'b0;
    else if (acc_in.wr && acc_in.addr == ADDR_STATUS)
      wen_seen <= acc_in.data[SR_TIME_WEN];
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!clear_on_read_enable_n_in);
  sequence s_main_ok;
    !vdd_lt_bat_in [*8];
  endsequence
  AST_TWR_GATE: assert property (
    time_wr_ok_out == (acc_in.wr && acc_in.addr <= ADDR_TIME_LAST &&
      wen_seen))
    else $error("time write gate wrong");
  AST_RUN_ON_STOP: assert property (
    $rose(count_run_out) |-> $past(bus_stop_in))
    else $error("run without stop");
  AST_TICK_RUN: assert property (
    sec_tick_out |-> count_run_out) else $error("tick while held");
  AST_TICK_ONE: assert property (
    sec_tick_out |=> !sec_tick_out) else $error("tick too long");
  AST_MAIN_HOLD: assert property (
    s_main_ok |-> !on_backup_out) else $error("backup on good main");
  AST_RDATA_HOLD: assert property (
    !acc_in.rd |=> $stable(reg_rdata_out))
    else $error("read data moved");
  AST_XTAL_WR: assert property (
    $past(clear_on_read_enable_n_in, 2) && $changed(xtal_enable_out) |->
      $past(acc_in.wr, 2) && $past(acc_in.addr, 2) == ADDR_STATUS &&
      $past(acc_in.data[SR_OSC_DIS], 2) == !xtal_enable_out)
    else $error("osc enable moved without write");
  AST_CAP_RANGE: assert property (
    $past(clear_on_read_enable_n_in, 2) |-> load_cap_out inside {[7'h11:7'h53]})
    else $error("load cap out of range");
endmodule

bind rtcc_ctrl rtcc_ctrl_monitor u_mon (.*);

// file: bench/rtcc_host_model.sv
// host model issuing one-byte register transfers
`timescale 1ns/1ns
module rtcc_host_model (
  input  wire logic           clk_in,    // clock
  input  wire logic [7:0]     rdata_in,  // read data
  input  wire logic           ok_in,     // time write taken
  output rtcc_pkg::rtcc_acc_s acc_out,   // access
  output logic                start_out, // start pulse
  output logic                stop_out   // stop pulse
);
  import rtcc_pkg::*;
  initial
  begin
    acc_out = '0;
    start_out = 1'b0;
    stop_out = 1'b0;
  end
  // start, byte, stop; a write returns the accept flag
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(negedge clk_in);
    start_out = 1'b1;
    @(negedge clk_in);
    start_out = 1'b0;
    acc_out = '{w, !w, a, d};
    #1 q = {7'h00, ok_in};
    @(negedge clk_in);
    acc_out = '0;
    stop_out = 1'b1;
    if (!w) q = rdata_in;
    @(negedge clk_in);
    stop_out = 1'b0;
  endtask
endmodule

// file: bench/rtcc_ctrl_bench.sv
// self-checking testbench of the rtc control block
`timescale 1ns/1ns
module rtcc_ctrl_bench;
  import rtcc_pkg::*;
  logic        clk_in = 1'b0, clear_on_read_enable_n_in = 1'b0, osc_wave = 1'b0;
  logic        vdd_lt_bat_in = 1'b0, vdd_lt_trip_in = 1'b0;
  logic        bus_start_in, bus_stop_in, time_wr_ok_out, count_run_out;
  logic        sec_tick_out, xtal_enable_out, on_backup_out;
  logic        irq_fout_oe_out, irq_fout_o_out;
  logic        crystal_in_pin_in, xtal_osc_in;
  logic [7:0]  reg_rdata_out, q;
  logic [6:0]  load_cap_out;
  rtcc_acc_s   acc_in;
  rtcc_byte6_t time_in = 48'h05, alarm_in = 48'h0700;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, n;

  always #20 clk_in = ~clk_in;
  initial
  begin
    #7;
    forever #160 osc_wave = ~osc_wave;
  end
  // crystal stops when disabled; the external source runs then
  assign xtal_osc_in = osc_wave & xtal_enable_out;
  assign crystal_in_pin_in = osc_wave & !xtal_enable_out;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  rtcc_ctrl #(.OSC_PER_SEC(16), .ALARM_PULSE_CYCLES(20))
    uut (.*);
  rtcc_host_model host (.clk_in, .rdata_in(reg_rdata_out),
    .ok_in(time_wr_ok_out), .acc_out(acc_in), .start_out(bus_start_in),
    .stop_out(bus_stop_in));

  task chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, d);
    host.xfer(1'b1, a, d, q);
  endtask
  task rc(input logic [7:0] a, e);
    host.xfer(1'b0, a, 8'h00, q);
    chk("reg", q, e);
  endtask
  // count pin pulses over a fixed window
  task fcnt(input logic [7:0] v, input int e);
    logic p;
    wr(ADDR_INT_CTRL, v);
    repeat (20) @(negedge clk_in);
    n = 0;
    p = irq_fout_oe_out;
    repeat (1280)
    begin
      @(negedge clk_in);
      n += int'(irq_fout_oe_out & !p);
      p = irq_fout_oe_out;
    end
    chk("fout", 8'(n >= e - 1 && n <= e + 1), 8'h01);
  endtask
  task arm;
    alarm_in[0] = 8'h00;
    repeat (300) @(negedge clk_in);
    alarm_in[0] = 8'h85;
    repeat (300) if (irq_fout_oe_out !== 1'b1) @(negedge clk_in);
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(negedge clk_in);
    clear_on_read_enable_n_in = 1'b1;
    @(negedge clk_in);
    chk("xen", 8'(xtal_enable_out), 8'h01);
    chk("cap", 8'(load_cap_out), 8'h32);
    chk("odo", 8'(irq_fout_o_out), 8'h00);
    wr(8'h09, 8'hff);
    rc(ADDR_STATUS, 8'h01);
    for (int a = 8; a < 12; a++) rc(8'(a), 8'h00);
    wr(8'h00, 8'h00);
    chk("twr", q, 8'h00);
    chk("run", 8'(count_run_out), 8'h00);
    $display("reset test done");
    wr(ADDR_STATUS, 8'h10);
    wr(8'h00, 8'h00);
    chk("twr", q, 8'h01);
    chk("run", 8'(count_run_out), 8'h01);
    rc(ADDR_STATUS, 8'h10);
    wr(ADDR_STATUS, 8'h17);
    rc(ADDR_STATUS, 8'h10);
    wr(ADDR_DIGITAL_TRIM, 8'h05);
    rc(ADDR_DIGITAL_TRIM, 8'h05);
    wr(ADDR_STATUS, 8'h50);
    chk("xen", 8'(xtal_enable_out), 8'h00);
    repeat (300) if (sec_tick_out !== 1'b1) @(negedge clk_in);
    chk("tick", 8'(sec_tick_out), 8'h01);
    wr(ADDR_STATUS, 8'h10);
    $display("time write test done");
    wr(ADDR_INT_CTRL, 8'h20);
    vdd_lt_bat_in = 1'b1;
    repeat (8) @(negedge clk_in);
    chk("bk", 8'(on_backup_out), 8'h01);
    rc(ADDR_STATUS, 8'h12);
    wr(ADDR_ANALOG_TRIM, 8'h40);
    chk("cap", 8'(load_cap_out), 8'h31);
    wr(ADDR_STATUS, 8'h92);
    rc(ADDR_STATUS, 8'h92);
    rc(ADDR_STATUS, 8'h90);
    wr(ADDR_INT_CTRL, 8'h00);
    repeat (8) @(negedge clk_in);
    chk("bk", 8'(on_backup_out), 8'h00);
    chk("cap", 8'(load_cap_out), 8'h32);
    vdd_lt_trip_in = 1'b1;
    fcnt(8'h11, 0);
    fcnt(8'h01, 160);
    chk("bk", 8'(on_backup_out), 8'h01);
    vdd_lt_bat_in = 1'b0;
    vdd_lt_trip_in = 1'b0;
    fcnt(8'h02, 20);
    fcnt(8'h03, 5);
    $display("supply and output test done");
    wr(ADDR_STATUS, 8'h10);
    wr(ADDR_INT_CTRL, 8'h40);
    arm();
    chk("oe", 8'(irq_fout_oe_out), 8'h01);
    rc(ADDR_STATUS, 8'h14);
    fcnt(8'h41, 160);
    fcnt(8'h40, 0);
    wr(ADDR_STATUS, 8'h10);
    chk("oe", 8'(irq_fout_oe_out), 8'h00);
    wr(ADDR_INT_CTRL, 8'hc0);
    repeat (2)
    begin
      arm();
      n = 0;
      while (irq_fout_oe_out === 1'b1 && n < 100)
      begin
        @(negedge clk_in);
        n++;
      end
      chk("pulse", 8'(n), 8'h14);
    end
    wr(ADDR_INT_CTRL, 8'h00);
    wr(ADDR_STATUS, 8'h10);
    arm();
    rc(ADDR_STATUS, 8'h10);
    $display("alarm test done");
    stop_test();
  end
endmodule
